// File: shared/tosc_consts.svh
// Constants for the timeout supervisor configuration bank.
`ifndef TOSC_CONSTS_SVH
`define TOSC_CONSTS_SVH
`define TOSC_IDX_ACT       8'h30
`define TOSC_IDX_BASE_HI   8'h60
`define TOSC_IDX_BASE_LO   8'h61
`define TOSC_IDX_IRQ_SEL   8'h70
`define TOSC_IDX_IRQ_TYPE  8'h71
`define TOSC_IDX_DMA0      8'h74
`define TOSC_IDX_DMA1      8'h75
`define TOSC_IDX_CFG       8'hF0
`define TOSC_IDX_EVT_STAT  8'hF8
`define TOSC_IDX_EVT_CLR   8'hF9
`define TOSC_IDX_EVT_EN    8'hFA
`define TOSC_RST_ACT       8'h00
`define TOSC_RST_BASE      8'h00
`define TOSC_RST_IRQ_SEL   8'h00
`define TOSC_RST_IRQ_TYPE  8'h03
`define TOSC_DMA_NONE      8'h04
`define TOSC_RST_CFG       8'h02
`define TOSC_BASE_LO_MASK  8'hFC
`define TOSC_IRQ_TYPE_MASK 8'h02
`define TOSC_CFG_MASK      8'h0F
`define TOSC_CFG_TRI       0
`define TOSC_CFG_PWR       1
`define TOSC_CFG_PULL      2
`define TOSC_CFG_PP        3
`endif

// File: shared/tosc_pkg.sv
// Types for the timeout supervisor configuration bank.
`default_nettype none
package tosc_pkg;
	typedef struct packed {
		logic       push_pull;
		logic       pull_up_en;
		logic       hi_z;
		logic       timer_clk_en;
	} tosc_pad_ctl_t;
endpackage
`default_nettype wire

// File: design/tosc_bank.sv
// Configuration register bank of the timeout supervisor.
`include "tosc_consts.svh"
`default_nettype none
module tosc_bank
	import tosc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	input  wire logic       timeout_event_n,
	output var  logic       timeout_out_n,
	output var  logic       timeout_out_oe,
	output var  tosc_pad_ctl_t pad_ctl,
	output var  logic [7:0] irq_route,
	output var  logic [15:0] base_addr,
	output var  logic       irq_type_level,
	output var  logic       irq
);
	logic [7:0]    act_q;
	logic [7:0]    base_hi_q;
	logic [7:0]    base_lo_q;
	logic [7:0]    irq_sel_q;
	logic [7:0]    irq_type_q;
	logic [7:0]    cfg_q;
	logic [1:0]    evt_stat_q;
	logic [1:0]    evt_en_q;
	logic [2:0]    tout_sync_q;
	logic          tout_q;
	logic          tout_d;
	logic          unit_on;
	logic          acc_ok;
	logic          wr_ok;
	logic [7:0]    rd_mux;
	logic [1:0]    evt_set;
	tosc_pad_ctl_t pad_d;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
		return a == idx;
	endfunction

	assign unit_on = act_q[0];
	// Activation and the unit's own event registers stay reachable always.
	assign acc_ok = unit_on || hit(reg_addr, `TOSC_IDX_ACT) || hit(reg_addr, `TOSC_IDX_EVT_STAT)
		|| hit(reg_addr, `TOSC_IDX_EVT_CLR) || hit(reg_addr, `TOSC_IDX_EVT_EN);
	assign wr_ok = reg_wr && acc_ok;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			act_q <= `TOSC_RST_ACT;
		end else if (wr_ok && hit(reg_addr, `TOSC_IDX_ACT)) begin
			act_q <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			base_hi_q <= `TOSC_RST_BASE;
			base_lo_q <= `TOSC_RST_BASE;
		end else begin
			if (wr_ok && hit(reg_addr, `TOSC_IDX_BASE_HI)) begin
				base_hi_q <= reg_wdata;
			end
			if (wr_ok && hit(reg_addr, `TOSC_IDX_BASE_LO)) begin
				base_lo_q <= reg_wdata & `TOSC_BASE_LO_MASK;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_sel_q  <= `TOSC_RST_IRQ_SEL;
			irq_type_q <= `TOSC_RST_IRQ_TYPE;
		end else begin
			if (wr_ok && hit(reg_addr, `TOSC_IDX_IRQ_SEL)) begin
				irq_sel_q <= reg_wdata;
			end
			if (wr_ok && hit(reg_addr, `TOSC_IDX_IRQ_TYPE)) begin
				irq_type_q <= (irq_type_q & ~`TOSC_IRQ_TYPE_MASK) | (reg_wdata & `TOSC_IRQ_TYPE_MASK);
			end
		end
	end

	// Power mode only gates the timer; register access is unaffected by it.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_q <= `TOSC_RST_CFG;
		end else if (wr_ok && hit(reg_addr, `TOSC_IDX_CFG)) begin
			cfg_q <= reg_wdata & `TOSC_CFG_MASK;
		end
	end

	// The timeout event pin is synchronised; a change counts when stages two and three agree.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tout_sync_q <= 3'h7;
		end else begin
			tout_sync_q <= {tout_sync_q[1:0], timeout_event_n};
		end
	end

	always_comb begin
		tout_d = tout_q;
		if (tout_sync_q[1] == tout_sync_q[2]) begin
			tout_d = tout_sync_q[2];
		end
		if (!(cfg_q[`TOSC_CFG_PWR] && unit_on)) begin
			tout_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tout_q <= 1'b1;
		end else begin
			tout_q <= tout_d;
		end
	end

	always_comb begin
		pad_d.push_pull    = cfg_q[`TOSC_CFG_PP];
		pad_d.pull_up_en   = cfg_q[`TOSC_CFG_PULL];
		pad_d.hi_z         = cfg_q[`TOSC_CFG_TRI] && !unit_on;
		pad_d.timer_clk_en = cfg_q[`TOSC_CFG_PWR] && unit_on;
	end

	// Pad outputs: open-drain drives only low, push-pull drives both levels.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pad_ctl        <= '0;
			timeout_out_n  <= 1'b1;
			timeout_out_oe <= 1'b0;
		end else begin
			pad_ctl        <= pad_d;
			timeout_out_n  <= tout_d;
			timeout_out_oe <= !pad_d.hi_z && (pad_d.push_pull || !tout_d);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_route      <= '0;
			base_addr      <= '0;
			irq_type_level <= 1'b0;
		end else begin
			irq_route      <= irq_sel_q;
			base_addr      <= {base_hi_q, base_lo_q};
			irq_type_level <= irq_type_q[1];
		end
	end

	// Event 0: timeout asserted; event 1: blocked access attempt.
	assign evt_set = {(reg_wr || reg_rd) && !acc_ok, tout_q && !tout_d};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			evt_stat_q <= '0;
			evt_en_q   <= '0;
		end else begin
			evt_stat_q <= (evt_stat_q & ~((wr_ok && hit(reg_addr, `TOSC_IDX_EVT_CLR)) ? reg_wdata[1:0] : 2'h0))
				| evt_set;
			if (wr_ok && hit(reg_addr, `TOSC_IDX_EVT_EN)) begin
				evt_en_q <= reg_wdata[1:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_stat_q & evt_en_q);
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		if (acc_ok) begin
			unique case (reg_addr)
				`TOSC_IDX_ACT:       rd_mux = act_q;
				`TOSC_IDX_BASE_HI:   rd_mux = base_hi_q;
				`TOSC_IDX_BASE_LO:   rd_mux = base_lo_q;
				`TOSC_IDX_IRQ_SEL:   rd_mux = irq_sel_q;
				`TOSC_IDX_IRQ_TYPE:  rd_mux = irq_type_q;
				`TOSC_IDX_DMA0:      rd_mux = `TOSC_DMA_NONE;
				`TOSC_IDX_DMA1:      rd_mux = `TOSC_DMA_NONE;
				`TOSC_IDX_CFG:       rd_mux = cfg_q;
				`TOSC_IDX_EVT_STAT:  rd_mux = {6'h00, evt_stat_q};
				`TOSC_IDX_EVT_EN:    rd_mux = {6'h00, evt_en_q};
				default:             rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end
endmodule // tosc_bank
`default_nettype wire

// File: sim/tosc_bank_chk.sv
// Checker for the timeout supervisor configuration bank.
`default_nettype none
module tosc_bank_chk
	import tosc_pkg::*;
(
	input wire logic          core_clk,
	input wire logic          rst,
	input wire logic [7:0]    reg_addr,
	input wire logic [7:0]    reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [7:0]    reg_rdata,
	input wire logic          timeout_out_n,
	input wire logic          timeout_out_oe,
	input wire tosc_pad_ctl_t pad_ctl,
	input wire logic [7:0]    irq_route
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire act = pad_ctl.timer_clk_en;
	sequence s_od_hi; !pad_ctl.push_pull && timeout_out_n; endsequence
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata");
	property p_dma; reg_rd && reg_addr[7:1] == 7'h3A && act && !$past(reg_wr) |=> reg_rdata == 8'h04; endproperty
	a_dma: assert property (p_dma) else $error("dma");
	property p_rsv; reg_rd && reg_addr == 8'hF0 |=> reg_rdata[7:4] == 4'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");
	property p_low; !act && !$past(act) |-> timeout_out_n; endproperty
	a_low: assert property (p_low) else $error("low");
	property p_hiz; pad_ctl.hi_z && $past(pad_ctl.hi_z) |-> !timeout_out_oe; endproperty
	a_hiz: assert property (p_hiz) else $error("hiz");
	property p_od; s_od_hi ##1 s_od_hi |-> !timeout_out_oe; endproperty
	a_od: assert property (p_od) else $error("od");
	property p_rt; reg_wr && reg_addr == 8'h70 && act && !$past(reg_wr) |=> ##1 irq_route == $past(reg_wdata, 2); endproperty
	a_rt: assert property (p_rt) else $error("route");
	property p_ref; reg_wr && reg_addr == 8'h70 && pad_ctl.hi_z && !$past(reg_wr) |=> ##1 $stable(irq_route); endproperty
	a_ref: assert property (p_ref) else $error("refuse");
endmodule // tosc_bank_chk
bind tosc_bank tosc_bank_chk i_chk(.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.timeout_out_n, .timeout_out_oe, .pad_ctl, .irq_route);
`default_nettype wire

// File: sim/test_tosc_bank.sv
// Testbench for the timeout supervisor configuration bank.
`default_nettype none
module test_tosc_bank
	import tosc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, timeout_event_n = 1;
	logic [7:0]    reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, irq_route;
	logic          timeout_out_n, timeout_out_oe, irq_type_level, irq;
	logic [15:0]   base_addr;
	tosc_pad_ctl_t pad_ctl;
	int            mismatches = 0, num_checks = 0;
	logic [7:0]    ri[8] = '{8'hF0, 8'h70, 8'h71, 8'h74, 8'h75, 8'h60, 8'h61, 8'h40};
	logic [7:0]    re[8] = '{8'h02, 8'h00, 8'h03, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
	always #4 core_clk = ~core_clk;
	tosc_bank i_tosc_bank(.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timeout_event_n,
		.timeout_out_n, .timeout_out_oe, .pad_ctl, .irq_route, .base_addr, .irq_type_level, .irq);
	task chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task w(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task r(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, e);
	endtask
	task nx;
		@(posedge core_clk);
		@(negedge core_clk);
	endtask
	task wo(input logic e);
		for (int i = 0; i < 12 && timeout_out_n !== e; i++) @(negedge core_clk);
		chk({7'h00, timeout_out_n}, {7'h00, e});
	endtask
	task final_report;
		if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		nx;
		chk({4'h0, pad_ctl}, 8'h00);
		r(8'h74, 8'h00);
		r(8'hF8, 8'h02);
		w(8'hFA, 8'h02);
		nx;
		chk({7'h00, irq}, 8'h01);
		w(8'hFA, 8'h00);
		nx;
		chk({7'h00, irq}, 8'h00);
		w(8'hF9, 8'h02);
		w(8'hFA, 8'h02);
		nx;
		chk({7'h00, irq}, 8'h00);
		w(8'h30, 8'h01);
		for (int k = 0; k < 8; k++) r(ri[k], re[k]);
		w(8'h61, 8'hFF);
		r(8'h61, 8'hFC);
		chk(base_addr[7:0], 8'hFC);
		chk(base_addr[15:8], 8'h00);
		w(8'h71, 8'h00);
		r(8'h71, 8'h01);
		chk({7'h00, irq_type_level}, 8'h00);
		w(8'h70, 8'h5A);
		w(8'hF0, 8'hFF);
		r(8'hF0, 8'h0F);
		chk({4'h0, pad_ctl}, 8'h0D);
		@(posedge core_clk);
		timeout_event_n <= 1'b0;
		wo(1'b0);
		chk({7'h00, timeout_out_oe}, 8'h01);
		w(8'hF0, 8'h0D);
		wo(1'b1);
		chk({4'h0, pad_ctl}, 8'h0C);
		w(8'hF0, 8'h03);
		wo(1'b0);
		@(posedge core_clk);
		timeout_event_n <= 1'b1;
		wo(1'b1);
		w(8'h30, 8'h00);
		nx;
		chk({4'h0, pad_ctl}, 8'h02);
		chk({7'h00, timeout_out_oe}, 8'h00);
		w(8'h70, 8'hFF);
		w(8'h30, 8'h01);
		r(8'h70, 8'h5A);
		final_report();
	end
endmodule // test_tosc_bank
`default_nettype wire
